/* File: core/dcsw_core.sv */
// Control word decoder and status word builder of the drive
`timescale 1ns/100ps
`include "dcsw_params.svh"
module dcsw_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic telegramDone,
  input wire logic telegramError,
  input wire logic [15:0] first_process_word,
  input wire logic [15:0] second_process_word,
  input wire logic [7:0] telegramProfile,
  input wire logic multiSetupEn,
  input wire logic [1:0] reverseSrc,
  input wire logic [1:0] coastMode,
  input wire logic [1:0] brakeMode,
  input wire logic [1:0] startMode,
  input wire logic [1:0] setupMode,
  input wire logic [1:0] presetMode,
  input wire logic dinCoastN,
  input wire logic dinBrakeN,
  input wire logic dinStart,
  input wire logic dinReverse,
  input wire logic [1:0] dinSetup,
  input wire logic [1:0] dinPreset,
  input wire logic dinHardStop,
  input wire logic doutBusAssigned,
  input wire logic relayBusAssigned,
  input wire logic driveReady,
  input wire logic tripActive,
  input wire logic tripLocked,
  input wire logic warningActive,
  input wire logic speedAtRef,
  input wire logic localControl,
  input wire logic panelStop,
  input wire logic freqLimitOk,
  input wire logic voltageWarn,
  input wire logic currentLimit,
  input wire logic thermalWarn,
  input wire logic [15:0] outputFreq,
  output logic [15:0] statusWord,
  output logic [15:0] freqWord,
  output logic [15:0] referenceWord,
  output logic [1:0] presetSel,
  output logic dcBrakeReq,
  output logic coastReq,
  output logic quickStopReq,
  output logic freezeReq,
  output logic rampStopReq,
  output logic runCmd,
  output logic tripResetPulse,
  output logic jogSel,
  output logic rampPairSel,
  output logic digitalOut,
  output logic relayOut,
  output logic [1:0] setupSel,
  output logic reverseCmd
);
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] ref_q, ref_d;
  logic resetBit_q, resetBit_d;
  logic pulse_q, pulse_d;
  logic [15:0] stat_q, stat_d;
  logic [15:0] freq_q, freq_d;
  logic accept;
  logic coastBus, brakeBus, startBus;
  logic coastEff, brakeEff, startEff;
  logic [1:0] setupEff, presetEff;

  // Word taken only on a clean, valid, correctly profiled telegram
  assign accept = telegramDone && !telegramError
    && telegramProfile == `DCSW_PROFILE_THIS
    && first_process_word[`DCSW_CW_VALID];

  always_comb begin
    ctrl_d = ctrl_q;
    ref_d = ref_q;
    resetBit_d = resetBit_q;
    pulse_d = 1'b0;
    if (accept) begin
      ctrl_d = first_process_word;
      ref_d = second_process_word;
      resetBit_d = first_process_word[`DCSW_CW_RESET];
      pulse_d = first_process_word[`DCSW_CW_RESET] & ~resetBit_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `DCSW_CW_RESET_VAL;
      ref_q <= 16'h0000;
      resetBit_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ref_q <= ref_d;
      resetBit_q <= resetBit_d;
      pulse_q <= pulse_d;
    end
  end

  // Active-high "run permitted" sense for each gated function
  assign coastBus = ctrl_q[`DCSW_CW_COAST];
  assign brakeBus = ctrl_q[`DCSW_CW_DCBRAKE];
  assign startBus = ctrl_q[`DCSW_CW_START];

  dcsw_gate_if gCoast();
  dcsw_gate_if gBrake();
  dcsw_gate_if gStart();
  dcsw_gate_if gSetup0();
  dcsw_gate_if gSetup1();
  dcsw_gate_if gPre0();
  dcsw_gate_if gPre1();

  // Mode settings are 2-bit codes of the gate enum
  assign gCoast.busBit = coastBus;
  assign gCoast.pinBit = dinCoastN;
  assign gCoast.mode = dcsw_pkg::dcsw_gate_t'(coastMode);
  assign gBrake.busBit = brakeBus;
  assign gBrake.pinBit = dinBrakeN;
  assign gBrake.mode = dcsw_pkg::dcsw_gate_t'(brakeMode);
  assign gStart.busBit = startBus;
  assign gStart.pinBit = dinStart;
  assign gStart.mode = dcsw_pkg::dcsw_gate_t'(startMode);
  assign gSetup0.busBit = ctrl_q[`DCSW_CW_SETUP_LO];
  assign gSetup0.pinBit = dinSetup[0];
  assign gSetup0.mode = dcsw_pkg::dcsw_gate_t'(setupMode);
  assign gSetup1.busBit = ctrl_q[`DCSW_CW_SETUP_LO + 1];
  assign gSetup1.pinBit = dinSetup[1];
  assign gSetup1.mode = dcsw_pkg::dcsw_gate_t'(setupMode);
  assign gPre0.busBit = ctrl_q[`DCSW_CW_PRESET_LO];
  assign gPre0.pinBit = dinPreset[0];
  assign gPre0.mode = dcsw_pkg::dcsw_gate_t'(presetMode);
  assign gPre1.busBit = ctrl_q[`DCSW_CW_PRESET_LO + 1];
  assign gPre1.pinBit = dinPreset[1];
  assign gPre1.mode = dcsw_pkg::dcsw_gate_t'(presetMode);

  dcsw_gate uCoast (.g(gCoast));
  dcsw_gate uBrake (.g(gBrake));
  dcsw_gate uStart (.g(gStart));
  dcsw_gate uSetup0 (.g(gSetup0));
  dcsw_gate uSetup1 (.g(gSetup1));
  dcsw_gate uPre0 (.g(gPre0));
  dcsw_gate uPre1 (.g(gPre1));

  assign coastEff = gCoast.result;
  assign brakeEff = gBrake.result;
  assign startEff = gStart.result;
  assign setupEff = {gSetup1.result, gSetup0.result};
  assign presetEff = {gPre1.result, gPre0.result};

  // Command outputs are decoded from the latched word and the digital inputs
  assign presetSel = presetEff;
  assign dcBrakeReq = ~brakeEff;
  assign coastReq = ~coastEff;
  assign quickStopReq = ~ctrl_q[`DCSW_CW_QSTOP];
  assign freezeReq = ~ctrl_q[`DCSW_CW_FREEZE];
  // Freeze masks the ramp stop; coast, brake and dinHardStop still clear runCmd
  assign rampStopReq = ~startEff & ~freezeReq;
  assign runCmd = (startEff | freezeReq) & coastEff & brakeEff & ~dinHardStop;
  assign tripResetPulse = pulse_q;
  assign jogSel = ctrl_q[`DCSW_CW_JOG];
  assign rampPairSel = ctrl_q[`DCSW_CW_RAMP];
  assign digitalOut = doutBusAssigned & ctrl_q[`DCSW_CW_DOUT];
  assign relayOut = relayBusAssigned & ctrl_q[`DCSW_CW_RELAY];
  assign setupSel = multiSetupEn ? setupEff : 2'h0;
  // Reverse sources: input only, link, and, or
  always_comb begin
    case (dcsw_pkg::dcsw_gate_t'(reverseSrc))
      dcsw_pkg::DCSW_GATE_INPUT: reverseCmd = dinReverse;
      dcsw_pkg::DCSW_GATE_BUS: reverseCmd = ctrl_q[`DCSW_CW_REVERSE];
      dcsw_pkg::DCSW_GATE_AND: reverseCmd = ctrl_q[`DCSW_CW_REVERSE] & dinReverse;
      default: reverseCmd = ctrl_q[`DCSW_CW_REVERSE] | dinReverse;
    endcase
  end
  assign referenceWord = ref_q;

  always_comb begin
    stat_d = 16'h0000;
    stat_d[0] = driveReady;
    stat_d[1] = driveReady & coastReq;
    stat_d[2] = coastEff & ~tripActive;
    stat_d[3] = tripActive;
    stat_d[6] = tripLocked;
    stat_d[7] = warningActive;
    stat_d[8] = speedAtRef & (outputFreq != 16'h0000);
    stat_d[9] = ~localControl & ~panelStop;
    stat_d[10] = freqLimitOk;
    stat_d[11] = runCmd | (outputFreq != 16'h0000);
    stat_d[13] = voltageWarn;
    stat_d[14] = currentLimit;
    stat_d[15] = thermalWarn;
    freq_d = outputFreq;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= 16'h0000;
      freq_q <= 16'h0000;
    end else begin
      stat_q <= stat_d;
      freq_q <= freq_d;
    end
  end

  assign statusWord = stat_q;
  assign freqWord = freq_q;

  sequence s_word_taken;
    telegramDone && !telegramError && telegramProfile == `DCSW_PROFILE_THIS
      && first_process_word[`DCSW_CW_VALID];
  endsequence
  sequence s_reset_rise;
    s_word_taken ##0 (first_process_word[`DCSW_CW_RESET] && !resetBit_q);
  endsequence

  a_word_latch: assert property (@(posedge core_clk) disable iff (!nrst)
    s_word_taken |=> ctrl_q == $past(first_process_word))
    else $error("Control word not latched");
  a_bad_telegram: assert property (@(posedge core_clk) disable iff (!nrst)
    (telegramDone && telegramError) |=> $stable(ctrl_q))
    else $error("Errored telegram changed control word");
  a_profile_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    (telegramProfile != `DCSW_PROFILE_THIS) |=> $stable(ctrl_q))
    else $error("Other profile changed control word");
  a_invalid_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
    (!first_process_word[`DCSW_CW_VALID]) |=> $stable(ctrl_q) && !tripResetPulse)
    else $error("Invalid word acted upon");
  a_reset_edge: assert property (@(posedge core_clk) disable iff (!nrst)
    s_reset_rise |=> tripResetPulse ##1 !tripResetPulse)
    else $error("Trip reset pulse wrong");
  a_reset_steady: assert property (@(posedge core_clk) disable iff (!nrst)
    tripResetPulse |-> $past(resetBit_q) == 1'b0 && resetBit_q == 1'b1)
    else $error("Reset pulse without rising edge");
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (freezeReq && coastEff && brakeEff && !dinHardStop) |-> runCmd && !rampStopReq)
    else $error("Stop not ignored under freeze");
  a_coast_stop: assert property (@(posedge core_clk) disable iff (!nrst)
    !coastEff |-> coastReq && !runCmd ##1 !statusWord[2])
    else $error("Coast did not stop drive");
  a_status_run: assert property (@(posedge core_clk) disable iff (!nrst)
    (outputFreq != 16'h0000) |=> statusWord[11])
    else $error("Running bit missing");
  a_status_trip: assert property (@(posedge core_clk) disable iff (!nrst)
    tripActive |=> statusWord[3] && !statusWord[2])
    else $error("Trip bit wrong");
  a_unused_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    statusWord[5:4] == 2'h0 && statusWord[12] == 1'b0)
    else $error("Unused status bits set");
  a_link_ctrl: assert property (@(posedge core_clk) disable iff (!nrst)
    (localControl || panelStop) |=> !statusWord[9])
    else $error("Link control bit wrong");
  a_setup_single: assert property (@(posedge core_clk) disable iff (!nrst)
    !multiSetupEn |-> setupSel == 2'h0)
    else $error("Setup changed without multi-setup");
  a_ref_latch: assert property (@(posedge core_clk) disable iff (!nrst)
    s_word_taken |=> referenceWord == $past(second_process_word))
    else $error("Reference value not latched");
  a_freq_echo: assert property (@(posedge core_clk) disable iff (!nrst)
    1'b1 |=> freqWord == $past(outputFreq))
    else $error("Frequency word not echoed");
  a_ready_bits: assert property (@(posedge core_clk) disable iff (!nrst)
    !driveReady |=> statusWord[1:0] == 2'h0)
    else $error("Ready bits set while not ready");
  a_lock_bit: assert property (@(posedge core_clk) disable iff (!nrst)
    tripLocked |=> statusWord[6])
    else $error("Trip lock bit missing");
  a_warn_bit: assert property (@(posedge core_clk) disable iff (!nrst)
    warningActive |=> statusWord[7])
    else $error("Warning bit missing");
  a_speed_bit: assert property (@(posedge core_clk) disable iff (!nrst)
    !speedAtRef |=> !statusWord[8])
    else $error("Speed bit set off reference");
  a_reverse_input: assert property (@(posedge core_clk) disable iff (!nrst)
    reverseSrc == 2'h0 |-> reverseCmd == dinReverse)
    else $error("Link reversed in input-only mode");
  a_dout_assign: assert property (@(posedge core_clk) disable iff (!nrst)
    !doutBusAssigned |-> !digitalOut)
    else $error("Digital output driven while not assigned");
  a_relay_assign: assert property (@(posedge core_clk) disable iff (!nrst)
    !relayBusAssigned |-> !relayOut)
    else $error("Relay driven while not assigned");
endmodule

/* File: core/dcsw_gate.sv */
// Combines one command bit from the link with its digital input
`timescale 1ns/100ps
module dcsw_gate (
  dcsw_gate_if.gate g
);
  always_comb begin
    case (g.mode)
      dcsw_pkg::DCSW_GATE_INPUT: g.result = g.pinBit;
      dcsw_pkg::DCSW_GATE_BUS: g.result = g.busBit;
      dcsw_pkg::DCSW_GATE_AND: g.result = g.busBit & g.pinBit;
      default: g.result = g.busBit | g.pinBit;
    endcase
  end
endmodule

/* File: shared/dcsw_gate_if.sv */
// Bus bit, input bit, mode and combined result
`timescale 1ns/100ps
interface dcsw_gate_if;
  logic busBit;
  logic pinBit;
  dcsw_pkg::dcsw_gate_t mode;
  logic result;
  modport src (output busBit, output pinBit, output mode, input result);
  modport gate (input busBit, input pinBit, input mode, output result);
endinterface

/* File: shared/dcsw_params.svh */
// Constants for the drive control/status word block
`ifndef DCSW_PARAMS_SVH
`define DCSW_PARAMS_SVH
`define DCSW_PROFILE_THIS 8'h01
`define DCSW_CW_PRESET_LO 0
`define DCSW_CW_DCBRAKE 2
`define DCSW_CW_COAST 3
`define DCSW_CW_QSTOP 4
`define DCSW_CW_FREEZE 5
`define DCSW_CW_START 6
`define DCSW_CW_RESET 7
`define DCSW_CW_JOG 8
`define DCSW_CW_RAMP 9
`define DCSW_CW_VALID 10
`define DCSW_CW_DOUT 11
`define DCSW_CW_RELAY 12
`define DCSW_CW_SETUP_LO 13
`define DCSW_CW_REVERSE 15
`define DCSW_CW_RESET_VAL 16'h0000
`endif

/* File: shared/dcsw_pkg.sv */
// Types for the drive control/status word block
package dcsw_pkg;
  // Gate modes for combining a bus bit with a digital input
  typedef enum logic [1:0] {
    DCSW_GATE_INPUT = 2'h0,
    DCSW_GATE_BUS = 2'h1,
    DCSW_GATE_AND = 2'h2,
    DCSW_GATE_OR = 2'h3
  } dcsw_gate_t;
  typedef enum logic [1:0] {
    DCSW_RUN_IDLE = 2'h0,
    DCSW_RUN_ACTIVE = 2'h1,
    DCSW_RUN_STOPPING = 2'h3
  } dcsw_run_t;
endpackage

/* File: verification/dcsw_master_model.sv */
// Serial master model that hands finished telegrams to the block
`timescale 1ns/100ps
module dcsw_master_model (
  input wire logic core_clk,
  output logic telegramDone,
  output logic telegramError,
  output logic [15:0] first_process_word,
  output logic [15:0] second_process_word
);
  initial begin
    telegramDone = 1'b0;
    telegramError = 1'b0;
    first_process_word = 16'h0000;
    second_process_word = 16'hffff;
  end
  // Words mean nothing outside the done cycle, so they are inverted after it
  task automatic send(input logic [15:0] cw, input logic [15:0] rv, input logic bad);
    @(posedge core_clk);
    #1;
    telegramDone = 1'b1;
    telegramError = bad;
    first_process_word = cw;
    second_process_word = rv;
    @(posedge core_clk);
    #1;
    telegramDone = 1'b0;
    telegramError = ~bad;
    first_process_word = ~cw;
    second_process_word = ~rv;
  endtask
endmodule

/* File: verification/drive_control_status_word_bench.sv */
// Self-checking bench of the control and status word block
`timescale 1ns/100ps
module drive_control_status_word_bench;
  logic core_clk = 1'b0, nrst = 1'b0, telegramDone, telegramError;
  logic [15:0] first_process_word, second_process_word, outputFreq = 16'h0000;
  logic [15:0] statusWord, freqWord, referenceWord;
  logic [7:0] telegramProfile = 8'h01;
  logic [1:0] reverseSrc = 2'h1, presetMode = 2'h1, dinSetup = 2'h0, dinPreset = 2'h0;
  logic [1:0] presetSel, setupSel;
  logic [1:0] coastMode = 2'h1, brakeMode = 2'h1, startMode = 2'h1, setupMode = 2'h1;
  logic multiSetupEn = 1'b1, dinCoastN = 1'b1, dinBrakeN = 1'b1, dinStart = 1'b0;
  logic dinReverse = 1'b0, dinHardStop = 1'b0, doutBusAssigned = 1'b1, relayBusAssigned = 1'b1;
  logic driveReady = 1'b1, tripActive = 1'b0, tripLocked = 1'b0, warningActive = 1'b0;
  logic speedAtRef = 1'b0, localControl = 1'b0, panelStop = 1'b0, freqLimitOk = 1'b0;
  logic voltageWarn = 1'b0, currentLimit = 1'b0, thermalWarn = 1'b0;
  logic dcBrakeReq, coastReq, quickStopReq, freezeReq, rampStopReq, runCmd;
  logic tripResetPulse, jogSel, rampPairSel, digitalOut, relayOut, reverseCmd;
  int nFail = 0, checksDone = 0;

  // Gate modes start on the link; the gate test moves them to input, AND and OR modes
  dcsw_core uut (
    .core_clk(core_clk),
    .nrst(nrst),
    .telegramDone(telegramDone),
    .telegramError(telegramError),
    .first_process_word(first_process_word),
    .second_process_word(second_process_word),
    .telegramProfile(telegramProfile),
    .multiSetupEn(multiSetupEn),
    .reverseSrc(reverseSrc),
    .coastMode(coastMode),
    .brakeMode(brakeMode),
    .startMode(startMode),
    .setupMode(setupMode),
    .presetMode(presetMode),
    .dinCoastN(dinCoastN),
    .dinBrakeN(dinBrakeN),
    .dinStart(dinStart),
    .dinReverse(dinReverse),
    .dinSetup(dinSetup),
    .dinPreset(dinPreset),
    .dinHardStop(dinHardStop),
    .doutBusAssigned(doutBusAssigned),
    .relayBusAssigned(relayBusAssigned),
    .driveReady(driveReady),
    .tripActive(tripActive),
    .tripLocked(tripLocked),
    .warningActive(warningActive),
    .speedAtRef(speedAtRef),
    .localControl(localControl),
    .panelStop(panelStop),
    .freqLimitOk(freqLimitOk),
    .voltageWarn(voltageWarn),
    .currentLimit(currentLimit),
    .thermalWarn(thermalWarn),
    .outputFreq(outputFreq),
    .statusWord(statusWord),
    .freqWord(freqWord),
    .referenceWord(referenceWord),
    .presetSel(presetSel),
    .dcBrakeReq(dcBrakeReq),
    .coastReq(coastReq),
    .quickStopReq(quickStopReq),
    .freezeReq(freezeReq),
    .rampStopReq(rampStopReq),
    .runCmd(runCmd),
    .tripResetPulse(tripResetPulse),
    .jogSel(jogSel),
    .rampPairSel(rampPairSel),
    .digitalOut(digitalOut),
    .relayOut(relayOut),
    .setupSel(setupSel),
    .reverseCmd(reverseCmd)
  );
  dcsw_master_model master (
    .core_clk(core_clk),
    .telegramDone(telegramDone),
    .telegramError(telegramError),
    .first_process_word(first_process_word),
    .second_process_word(second_process_word)
  );

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic tx(input logic [15:0] cw, input logic bad);
    master.send(cw, ~cw, bad);
  endtask

  task automatic t_decode;
    logic [1:0] b;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      b = 2'(i);
      w = {b[0], b, b[1], b[0], 1'b1, b[1], b[0], 6'h1f, b};
      tx(w, 1'b0);
      chk(16'(presetSel), 16'(b));
      chk(16'(setupSel), 16'(b));
      chk(16'({rampPairSel, jogSel}), 16'(b));
      chk(16'({reverseCmd, relayOut, digitalOut}), 16'({b[0], b[1], b[0]}));
      chk(referenceWord, ~w);
    end
    $display("decode test done");
  endtask

  task automatic t_stops;
    logic [15:0] s, e;
    for (int k = 2; k < 8; k++) begin
      tx(16'h047c & ~(16'h0001 << k), 1'b0);
      s = 16'({rampStopReq, freezeReq, quickStopReq, coastReq, dcBrakeReq});
      e = k < 7 ? 16'h0001 << (k - 2) : 16'h0000;
      chk(s, e);
    end
    $display("stop test done");
  endtask

  task automatic t_refuse;
    tx(16'h047d, 1'b0);
    tx(16'h047e, 1'b1);
    chk(16'(presetSel), 16'h0001);
    telegramProfile = 8'h02;
    tx(16'h047e, 1'b0);
    chk(16'(presetSel), 16'h0001);
    telegramProfile = 8'h01;
    tx(16'h007e, 1'b0);
    chk(16'(presetSel), 16'h0001);
    chk(referenceWord, 16'hfb82);
    $display("refuse test done");
  endtask

  task automatic t_trip;
    tx(16'h047c, 1'b0);
    tx(16'h04fc, 1'b0);
    chk(16'(tripResetPulse), 16'h0001);
    tick(1);
    chk(16'(tripResetPulse), 16'h0000);
    tx(16'h04fc, 1'b0);
    chk(16'(tripResetPulse), 16'h0000);
    tx(16'h047c, 1'b1);
    tx(16'h04fc, 1'b0);
    chk(16'(tripResetPulse), 16'h0000);
    $display("trip reset test done");
  endtask

  task automatic t_freeze;
    tx(16'h047c, 1'b0);
    chk(16'(runCmd), 16'h0001);
    tx(16'h045c, 1'b0);
    chk(16'({freezeReq, runCmd}), 16'h0003);
    tx(16'h041c, 1'b0);
    chk(16'({rampStopReq, runCmd}), 16'h0001);
    dinHardStop = 1'b1;
    #1;
    chk(16'(runCmd), 16'h0000);
    tick(1);
    dinHardStop = 1'b0;
    tx(16'h0454, 1'b0);
    chk(16'(runCmd), 16'h0000);
    $display("freeze test done");
  endtask

  task automatic t_gate;
    reverseSrc = 2'h0;
    dinReverse = 1'b1;
    presetMode = 2'h2;
    dinPreset = 2'h1;
    {coastMode, brakeMode, startMode, setupMode} = 8'hb0;
    {dinCoastN, dinStart, dinSetup} = 4'h6;
    tx(16'h1c7b, 1'b0);
    chk(16'({reverseCmd, presetSel}), 16'h0005);
    chk(16'({coastReq, dcBrakeReq, rampStopReq, setupSel}), 16'h0012);
    chk(16'({relayOut, digitalOut}), 16'h0003);
    {multiSetupEn, doutBusAssigned, relayBusAssigned} = 3'h0;
    tick(1);
    chk(16'({setupSel, relayOut, digitalOut}), 16'h0000);
    {multiSetupEn, doutBusAssigned, relayBusAssigned} = 3'h7;
    {coastMode, brakeMode, startMode, setupMode} = 8'h55;
    {dinCoastN, dinStart, dinSetup, dinReverse, dinPreset} = 7'h40;
    reverseSrc = 2'h1;
    presetMode = 2'h1;
    $display("gate test done");
  endtask

  task automatic t_status;
    {tripActive, tripLocked, warningActive, speedAtRef} = 4'hf;
    {freqLimitOk, voltageWarn, thermalWarn} = 3'h7;
    outputFreq = 16'h0100;
    tick(1);
    chk(statusWord & 16'hfff8, 16'hafc8);
    chk(freqWord, 16'h0100);
    tx(16'h0474, 1'b0);
    {tripActive, tripLocked, warningActive, freqLimitOk, voltageWarn, thermalWarn} = 6'h00;
    {outputFreq, localControl, currentLimit} = 18'h00003;
    tick(1);
    chk(statusWord, 16'h4003);
    tx(16'h047c, 1'b0);
    {driveReady, localControl, currentLimit, speedAtRef} = 4'h0;
    tick(1);
    chk(statusWord, 16'h0a04);
    driveReady = 1'b1;
    $display("status test done");
  endtask

  // Reset in mid-run must also clear the remembered reset bit
  task automatic t_reset;
    outputFreq = 16'h0200;
    tx(16'h04fc, 1'b0);
    nrst = 1'b0;
    outputFreq = 16'h0000;
    tick(1);
    chk(statusWord, 16'h0000);
    chk(freqWord, 16'h0000);
    chk(referenceWord, 16'h0000);
    chk(16'({coastReq, freezeReq, tripResetPulse}), 16'h0006);
    nrst = 1'b1;
    tx(16'h04fc, 1'b0);
    chk(16'(tripResetPulse), 16'h0001);
    $display("reset test done");
  endtask

  task automatic endSim;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    chk(16'({coastReq, dcBrakeReq, quickStopReq, freezeReq}), 16'h000f);
    t_decode;
    t_stops;
    t_refuse;
    t_trip;
    t_freeze;
    t_gate;
    t_status;
    t_reset;
    endSim;
  end

  // A hang is cut short and counted as a mismatch
  initial begin
    #100000;
    nFail++;
    endSim;
  end
endmodule
